// File: sync_chan_map.svh
// Register bit positions, command codes and sizes for the sync channel.
// Assumes the includer uses these with the sync_chan_pkg types.
`ifndef SYNC_CHAN_MAP_SVH
`define SYNC_CHAN_MAP_SVH
`define CMD_FIELD_HI 7
`define CMD_FIELD_LO 6
`define CMD_RESET_RX_CRC 2'h1
`define CMD_RESET_TX_CRC 2'h2
`define CMD_RESET_EOM 2'h3
`define CMD_ERROR_RESET 3'h6
`define CMD_ERR_HI 5
`define CMD_ERR_LO 3
`define INT_PAR_SPECIAL 2
`define RXC_ENABLE 0
`define RXC_LOAD_INHIBIT 1
`define RXC_CRC_ENABLE 3
`define RXC_HUNT 4
`define RXC_AUTO_EN 5
`define RXC_LEN_HI 7
`define RXC_LEN_LO 6
`define MODE_PAR_EN 0
`define MODE_PAR_EVEN 1
`define MODE_SYNC_HI 5
`define MODE_SYNC_LO 4
`define TXC_CRC_EN 0
`define TXC_RTS 1
`define TXC_CRC16 2
`define TXC_ENABLE 3
`define TXC_LEN_HI 6
`define TXC_LEN_LO 5
`define XOPT_AUTO_EOM 1
`define MISC_SYNC6 0
`define MISC_PRESET 7
`define POLY_CRC16 16'h8005
`define POLY_CCITT 16'h1021
`define CRC_BITS 5'h10
`define EXT_SYNC_DELAY 2'h2
`endif

// File: sync_chan_pkg.sv
// Types shared by the byte-synchronous channel.
// Assumes sync_chan_map.svh holds the numeric constants.
package sync_chan_pkg;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_DATA = 2'b01,
      TX_SYNC = 2'b10,
      TX_CRC = 2'b11
   } tx_state_t;
endpackage : sync_chan_pkg

// File: byte_sync_tx_rx_framing.sv
// Byte-synchronous transmit/receive framing: sync, CRC, parity, modem lines.
// Assumes register writes arrive as one-cycle strobes with data, and that
// tx_bit_en / rx_bit_en are one-cycle bit-time enables on core_clk.
//
// Notes on behaviour
// - Underrun with latch clear sends CRC
// - Latch visible as status and event
// - Auto option clears latch on first byte
// - Disable mid character finishes character
// - Disable during CRC finishes sixteen bits
// - RTS pin is inverse of RTS bit
// - CTS reflected; auto-enables gates transmitter
// - Hunt only compares shift register with sync
// - Hunt on enable or hunt command
// - Hunt status with change event
// - Sync length from mode and misc bits
// - External sync: status follows sync pin
// - External sync low ends hunt
// - Sync pin pulses low on matches
// - Load inhibit strips sync characters
// - Receive length five to eight bits
// - Parity enable and sense, stored bit
// - Parity error latched until reset
// - CRC polynomial select bit
// - Preset value from misc bit
`timescale 1ns/1ps
`include "sync_chan_map.svh"
module byte_sync_tx_rx_framing (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Register write strobes and data
   input wire logic [7:0] wr_data,
   input wire logic command_reg_wr,
   input wire logic interrupt_control_reg_wr,
   input wire logic receive_control_reg_wr,
   input wire logic channel_mode_reg_wr,
   input wire logic transmit_control_reg_wr,
   input wire logic sync_pattern_low_wr,
   input wire logic sync_pattern_high_wr,
   input wire logic extended_option_reg_wr,
   input wire logic misc_line_control_reg_wr,
   input wire logic tx_data_wr,
   // Bit clocks and serial line
   input wire logic tx_bit_en,
   input wire logic rx_bit_en,
   input wire logic rx_data,
   output logic tx_data,
   // Modem and sync pins
   input wire logic cts_n,
   output logic rts_n,
   input wire logic sync_n_in,
   output logic sync_n_out,
   output logic sync_n_oe,
   // Status
   output logic tx_buffer_empty,
   output logic eom_status,
   output logic cts_status,
   output logic hunt_status,
   output logic ext_status_event,
   output logic parity_error,
   output logic special_rx_event,
   output logic [7:0] rx_fifo_data,
   output logic rx_fifo_valid
);
   logic [7:0] int_q;
   logic [7:0] rxc_q;
   logic [7:0] mode_q;
   logic [7:0] txc_q;
   logic [7:0] syn_lo_q;
   logic [7:0] syn_hi_q;
   logic [7:0] xopt_q;
   logic [7:0] misc_q;
   logic [7:0] tbuf_q;
   logic tbuf_full_q;
   logic eom_q;
   logic first_q;
   // Nine bits so an 8-bit character keeps its parity bit
   logic [8:0] tsh_q;
   logic [4:0] tcnt_q;
   logic [15:0] tcrc_q;
   logic [15:0] rcrc_q;
   logic tcrc_on_q;
   sync_chan_pkg::tx_state_t tst_q;
   logic [15:0] rsh_q;
   logic hunt_q;
   logic rx_en_q;
   logic syn_pulse_q;
   logic [3:0] rcnt_q;
   logic ext_prev_q;
   logic hunt_prev_q;
   logic eom_prev_q;
   logic [7:0] rxo_q;
   logic rxv_q;
   logic perr_q;

   wire [1:0] cmd = wr_data[`CMD_FIELD_HI:`CMD_FIELD_LO];
   wire [2:0] cmd_err = wr_data[`CMD_ERR_HI:`CMD_ERR_LO];
   wire [1:0] sync_sel = mode_q[`MODE_SYNC_HI:`MODE_SYNC_LO];
   wire ext_sync = &sync_sel;
   wire sync6 = misc_q[`MISC_SYNC6];
   wire crc16 = txc_q[`TXC_CRC16];
   wire [15:0] poly = crc16 ? `POLY_CRC16 : `POLY_CCITT;
   wire [15:0] preset = {16{misc_q[`MISC_PRESET]}};
   wire auto_en = rxc_q[`RXC_AUTO_EN];
   wire tx_go = txc_q[`TXC_ENABLE] & ~(auto_en & cts_n);
   wire par_en = mode_q[`MODE_PAR_EN];
   wire par_even = mode_q[`MODE_PAR_EVEN];
   // Character length 5..8 from the two length fields
   wire [3:0] tx_len = 4'h5 + {2'h0, txc_q[`TXC_LEN_HI:`TXC_LEN_LO]};
   wire [3:0] rx_len = 4'h5 + {2'h0, rxc_q[`RXC_LEN_HI:`RXC_LEN_LO]};
   wire [3:0] rx_tot = rx_len + {3'h0, par_en};
   wire [3:0] tx_tot = tx_len + {3'h0, par_en};
   // Sync pattern compare, left-justified receive pattern
   wire [15:0] pat16 = {syn_hi_q, syn_lo_q};
   // Newest bit enters at the top; compare includes the bit arriving now
   wire [15:0] rsh_shift = {rx_data, rsh_q[15:1]};
   wire match6 = rsh_shift[15:10] == syn_lo_q[5:0];
   wire match8 = rsh_shift[15:8] == syn_lo_q;
   wire match12 = rsh_shift[15:4] == pat16[15:4];
   wire match16 = rsh_shift == pat16;
   wire pat_match = (sync_sel == 2'h0) ? (sync6 ? match6 : match8) :
                    (sync_sel == 2'h1) ? (sync6 ? match12 : match16) :
                    1'b0;
   wire [7:0] tx_idle_char = sync6 ? {2'h0, syn_lo_q[5:0]} : syn_lo_q;
   // Transmit character with parity placed just above the data bits
   wire [7:0] tx_mask = 8'hFF >> (4'h8 - tx_len);
   wire tx_par = ^(tbuf_q & tx_mask) ^ ~par_even;
   wire [8:0] tx_par_word = {8'h00, tx_par} << tx_len;
   wire [8:0] tx_load = par_en ? ({1'b0, tbuf_q & tx_mask} | tx_par_word) :
                        {1'b0, tbuf_q};
   wire tx_start = tcnt_q == 5'h00;
   wire tx_out_bit = tx_start ? tx_load[0] : tsh_q[0];
   wire tcrc_fb = tcrc_q[15] ^ tx_out_bit;
   wire [15:0] tcrc_next = {tcrc_q[14:0], 1'b0} ^ (tcrc_fb ? poly : 16'h0);
   wire rcrc_fb = rcrc_q[15] ^ rx_data;
   wire [15:0] rcrc_next = {rcrc_q[14:0], 1'b0} ^ (rcrc_fb ? poly : 16'h0);
   // Received character: snapshot of the last rx_tot bits, right-justified
   // An 8-bit character with parity is nine bits; the parity bit drops off
   wire [15:0] rx_win = rsh_shift >> (5'h10 - {1'b0, rx_tot});
   wire [7:0] rx_char = rx_win[7:0];
   wire [7:0] len_mask = 8'hFF >> (4'h8 - rx_len);
   wire rx_par_calc = ^(rx_char & len_mask) ^ ~par_even;
   wire rx_par_bit = rx_win[rx_len];
   wire rx_par_bad = par_en & (rx_par_calc != rx_par_bit);
   wire strip = rxc_q[`RXC_LOAD_INHIBIT] & (rx_char == syn_lo_q);
   wire char_done = rx_bit_en & ~hunt_q & (rcnt_q + 4'h1 == rx_tot);
   wire rx_on = rxc_q[`RXC_ENABLE] & ~(auto_en & 1'b0);
   wire hunt_cmd = receive_control_reg_wr & wr_data[`RXC_HUNT];
   wire rx_first_en = receive_control_reg_wr & wr_data[`RXC_ENABLE] &
                      ~rx_en_q;
   // External sync: pin high means still hunting, as the status bit reads
   wire hunt_view = ext_sync ? sync_n_in : hunt_q;
   wire ext_low = ext_sync & ~sync_n_in;

   // Register writes
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         int_q <= 8'h00;
         rxc_q <= 8'h00;
         mode_q <= 8'h00;
         txc_q <= 8'h00;
         syn_lo_q <= 8'h00;
         syn_hi_q <= 8'h00;
         xopt_q <= 8'h00;
         misc_q <= 8'h00;
      end else begin
         if (interrupt_control_reg_wr) int_q <= wr_data;
         if (receive_control_reg_wr) rxc_q <= wr_data & ~(8'h01 << `RXC_HUNT);
         if (channel_mode_reg_wr) mode_q <= wr_data;
         if (transmit_control_reg_wr) txc_q <= wr_data;
         if (sync_pattern_low_wr) syn_lo_q <= wr_data;
         if (sync_pattern_high_wr) syn_hi_q <= wr_data;
         if (extended_option_reg_wr) xopt_q <= wr_data;
         if (misc_line_control_reg_wr) misc_q <= wr_data;
      end
   end

   // Transmit buffer and end-of-message latch
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tbuf_q <= 8'h00;
         tbuf_full_q <= 1'b0;
         eom_q <= 1'b1;
         first_q <= 1'b1;
      end else begin
         if (tx_data_wr) begin
            tbuf_q <= wr_data;
            tbuf_full_q <= 1'b1;
         end else if (tx_bit_en && tcnt_q == 5'h0 && tx_go && tbuf_full_q)
            tbuf_full_q <= 1'b0;
         if (tx_bit_en && tst_q == sync_chan_pkg::TX_CRC && tcnt_q == 5'h1)
            eom_q <= 1'b1;
         else if (command_reg_wr && cmd == `CMD_RESET_EOM)
            eom_q <= 1'b0;
         else if (tx_data_wr && first_q && xopt_q[`XOPT_AUTO_EOM])
            eom_q <= 1'b0;
         if (tx_data_wr) first_q <= 1'b0;
         else if (eom_q && tst_q != sync_chan_pkg::TX_DATA && !tbuf_full_q)
            first_q <= 1'b1;
      end
   end

   // Transmit shifter: one bit per bit time, and the next character's first
   // bit goes out at the very bit time after the last one, so no bit is
   // stretched. A character or the CRC runs to its end once started.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tst_q <= sync_chan_pkg::TX_IDLE;
         tsh_q <= 9'h1FF;
         tcnt_q <= 5'h00;
         tcrc_q <= 16'h0000;
         tcrc_on_q <= 1'b0;
         tx_data <= 1'b1;
      end else begin
         if (command_reg_wr && cmd == `CMD_RESET_TX_CRC) tcrc_q <= preset;
         if (tx_bit_en) begin
            if (!tx_start) begin
               tcnt_q <= tcnt_q - 5'h01;
               if (tst_q == sync_chan_pkg::TX_CRC) begin
                  // Disabled mid CRC: the rest of the sixteen come from sync
                  tx_data <= tx_go ? tcrc_q[15] : tsh_q[0];
                  tsh_q <= {1'b0, tsh_q[0], tsh_q[7:1]};
                  tcrc_q <= {tcrc_q[14:0], 1'b0};
               end else begin
                  tx_data <= tsh_q[0];
                  tsh_q <= {1'b1, tsh_q[8:1]};
                  if (tst_q == sync_chan_pkg::TX_DATA && tcrc_on_q)
                     tcrc_q <= tcrc_next;
               end
            end else if (!tx_go) begin
               tst_q <= sync_chan_pkg::TX_IDLE;
               tx_data <= 1'b1;
            end else if (tbuf_full_q) begin
               tst_q <= sync_chan_pkg::TX_DATA;
               tx_data <= tx_load[0];
               tsh_q <= {1'b1, tx_load[8:1]};
               tcnt_q <= {1'b0, tx_tot - 4'h1};
               tcrc_on_q <= txc_q[`TXC_CRC_EN];
               if (txc_q[`TXC_CRC_EN]) tcrc_q <= tcrc_next;
            end else if (!eom_q) begin
               tst_q <= sync_chan_pkg::TX_CRC;
               tx_data <= tcrc_q[15];
               tsh_q <= {1'b0, tx_idle_char};
               tcrc_q <= {tcrc_q[14:0], 1'b0};
               tcnt_q <= `CRC_BITS - 5'h01;
            end else begin
               tst_q <= sync_chan_pkg::TX_SYNC;
               tx_data <= tx_idle_char[0];
               tsh_q <= {2'b11, tx_idle_char[7:1]};
               tcnt_q <= sync6 ? 5'h05 : 5'h07;
            end
         end
      end
   end

   // Receiver: hunt, assembly, strip, parity, CRC
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rsh_q <= 16'h0000;
         hunt_q <= 1'b1;
         rx_en_q <= 1'b0;
         syn_pulse_q <= 1'b0;
         rcnt_q <= 4'h0;
         ext_prev_q <= 1'b0;
         rxo_q <= 8'h00;
         rxv_q <= 1'b0;
         perr_q <= 1'b0;
         rcrc_q <= 16'h0000;
      end else begin
         rx_en_q <= rxc_q[`RXC_ENABLE];
         rxv_q <= 1'b0;
         syn_pulse_q <= 1'b0;
         ext_prev_q <= ext_low;
         if (rx_bit_en && rx_on) begin
            rsh_q <= rsh_shift;
            if (!ext_sync && pat_match) syn_pulse_q <= 1'b1;
         end
         if (hunt_cmd || rx_first_en) begin
            hunt_q <= 1'b1;
            rcnt_q <= 4'h0;
         end else if (hunt_q) begin
            rcrc_q <= preset;
            if (ext_sync) begin
               if (ext_low && !ext_prev_q) hunt_q <= 1'b0;
            end else if (rx_bit_en && rx_on && pat_match) begin
               hunt_q <= 1'b0;
               rcnt_q <= 4'h0;
            end
         end else if (rx_bit_en && rx_on) begin
            rcnt_q <= char_done ? 4'h0 : rcnt_q + 4'h1;
            if (rxc_q[`RXC_CRC_ENABLE]) rcrc_q <= rcrc_next;
            if (char_done && !strip) begin
               rxo_q <= rx_char;
               rxv_q <= 1'b1;
            end
            if (char_done && rx_par_bad) perr_q <= 1'b1;
         end
         if (command_reg_wr && cmd == `CMD_RESET_RX_CRC) rcrc_q <= preset;
         if (command_reg_wr && cmd_err == `CMD_ERROR_RESET &&
             !(char_done && rx_par_bad && !hunt_q))
            perr_q <= 1'b0;
      end
   end

   // Status outputs and change events
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rts_n <= 1'b1;
         sync_n_out <= 1'b1;
         sync_n_oe <= 1'b0;
         tx_buffer_empty <= 1'b1;
         eom_status <= 1'b1;
         cts_status <= 1'b0;
         hunt_status <= 1'b1;
         ext_status_event <= 1'b0;
         parity_error <= 1'b0;
         special_rx_event <= 1'b0;
         rx_fifo_data <= 8'h00;
         rx_fifo_valid <= 1'b0;
         // Match the reset levels so no false change event follows reset
         hunt_prev_q <= 1'b1;
         eom_prev_q <= 1'b1;
      end else begin
         rts_n <= ~txc_q[`TXC_RTS];
         sync_n_out <= ~syn_pulse_q;
         sync_n_oe <= ~ext_sync;
         tx_buffer_empty <= ~tbuf_full_q;
         eom_status <= eom_q;
         cts_status <= ~cts_n;
         hunt_status <= hunt_view;
         hunt_prev_q <= hunt_view;
         eom_prev_q <= eom_q;
         ext_status_event <= (hunt_view != hunt_prev_q) |
                             (eom_q & ~eom_prev_q);
         parity_error <= perr_q;
         special_rx_event <= char_done & rx_par_bad & ~hunt_q &
                             int_q[`INT_PAR_SPECIAL];
         rx_fifo_data <= rxo_q;
         rx_fifo_valid <= rxv_q;
      end
   end
endmodule : byte_sync_tx_rx_framing

// File: byte_sync_tx_rx_framing_monitor.sv
// Port-level checks for the byte-synchronous framing block.
// Assumes it is bound into byte_sync_tx_rx_framing by the bench.
`timescale 1ns/1ps
module byte_sync_tx_rx_framing_monitor (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Register writes
   input wire logic [7:0] wr_data,
   input wire logic command_reg_wr,
   input wire logic receive_control_reg_wr,
   input wire logic channel_mode_reg_wr,
   input wire logic transmit_control_reg_wr,
   // Pins and status
   input wire logic cts_n,
   input wire logic rts_n,
   input wire logic sync_n_in,
   input wire logic sync_n_out,
   input wire logic sync_n_oe,
   input wire logic eom_status,
   input wire logic cts_status,
   input wire logic hunt_status,
   input wire logic ext_status_event,
   input wire logic parity_error,
   input wire logic special_rx_event
);
   wire err_reset = command_reg_wr && wr_data[5:3] == 3'h6;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   a_rts_low: assert property (
      transmit_control_reg_wr && wr_data[1] |-> ##[1:2] !rts_n)
      else $error("rts_n not low after bit set");
   a_cts_follow: assert property (
      $changed(cts_n) |-> ##[1:2] (cts_status == !cts_n))
      else $error("cts status does not follow pin");
   a_hunt_enter: assert property (
      receive_control_reg_wr && wr_data[4] && sync_n_in
      |-> ##[1:2] hunt_status) else $error("hunt not entered");
   a_hunt_event: assert property (
      $changed(hunt_status) |-> ##[0:1] ext_status_event)
      else $error("no event on hunt change");
   a_eom_event: assert property (
      $rose(eom_status) |-> ##[0:1] ext_status_event)
      else $error("no event on latch set");
   a_sync_pulse: assert property (
      sync_n_oe && $fell(sync_n_out) |=> sync_n_out)
      else $error("sync pulse longer than one cycle");
   a_ext_release: assert property (
      channel_mode_reg_wr && wr_data[5:4] == 2'b11 |-> ##[1:2] !sync_n_oe)
      else $error("sync pin still driven in external mode");
   a_ext_end: assert property (
      !sync_n_oe && $fell(sync_n_in) |-> ##[1:3] !hunt_status)
      else $error("hunt not left on external sync");
   a_par_hold: assert property (
      $fell(parity_error) |-> $past(err_reset) || $past(err_reset, 2))
      else $error("parity error cleared without reset");
   a_special_err: assert property (
      special_rx_event |-> ##[0:1] parity_error)
      else $error("special event without parity error");
endmodule : byte_sync_tx_rx_framing_monitor

// File: sync_line_model.sv
// Line partner: bit-time enables, receive stream, external sync pulse.
// Assumes the bench queues receive bits with send and reads tx_seen.
`timescale 1ns/1ps
module sync_line_model #(
   parameter int DIV = 4
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Line
   input wire logic tx_data,
   output logic tx_bit_en,
   output logic rx_bit_en,
   output logic rx_data,
   output logic ext_sync_n
);
   int div_q = 0;
   int ext_cnt = 10;
   logic rx_q[$];
   logic tx_seen[$];
   // Low for eight bit times, from two bit times after the last bit
   assign ext_sync_n = !(ext_cnt >= 2 && ext_cnt < 10);
   task automatic send(input logic [15:0] v, input int n, input bit arm);
      for (int i = 0; i < n; i++) rx_q.push_back(v[i]);
      ext_cnt = arm ? 0 : 10;
   endtask : send
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_q <= 0;
         rx_bit_en <= 1'b0;
         tx_bit_en <= 1'b0;
         rx_data <= 1'b0;
      end else begin
         div_q <= (div_q == DIV - 1) ? 0 : div_q + 1;
         rx_bit_en <= (div_q == 0);
         tx_bit_en <= (div_q == 2);
         if (tx_bit_en) tx_seen.push_back(tx_data);
         if (div_q == 0 && rx_q.size() == 0 && ext_cnt < 10)
            ext_cnt <= ext_cnt + 1;
         // Idle line toggles so a stale level never poses as sync
         if (div_q == 0) rx_data <= rx_q.size() ? rx_q.pop_front() : !rx_data;
      end
   end
endmodule : sync_line_model

// File: byte_sync_tx_rx_framing_tb_top.sv
// Bench for the framing block: modem pins, hunt, strip, parity, CRC.
// Assumes the line model makes bit enables every four core_clk cycles.
`timescale 1ns/1ps
module byte_sync_tx_rx_framing_tb_top;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic cts_n = 1'b1;
   logic [7:0] wr_data = 8'h00;
   logic [9:0] wr = 10'h000;
   logic [31:0] rng = 32'h0000B995;
   logic [7:0] got[$];
   int n_errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   wire tx_bit_en, rx_bit_en, rx_data, tx_data, ext_sync_n, rts_n;
   wire sync_n_out, sync_n_oe, tx_buffer_empty, eom_status, cts_status;
   wire hunt_status, parity_error, rx_fifo_valid;
   wire [7:0] rx_fifo_data;
   wire sync_pin = sync_n_oe ? sync_n_out : ext_sync_n;
   byte_sync_tx_rx_framing dut_u (
      .core_clk(core_clk), .reset_n(reset_n), .wr_data(wr_data),
      .command_reg_wr(wr[0]), .interrupt_control_reg_wr(wr[1]),
      .receive_control_reg_wr(wr[2]), .channel_mode_reg_wr(wr[3]),
      .transmit_control_reg_wr(wr[4]), .sync_pattern_low_wr(wr[5]),
      .sync_pattern_high_wr(wr[6]), .extended_option_reg_wr(wr[7]),
      .misc_line_control_reg_wr(wr[8]), .tx_data_wr(wr[9]),
      .tx_bit_en(tx_bit_en), .rx_bit_en(rx_bit_en), .rx_data(rx_data),
      .tx_data(tx_data), .cts_n(cts_n), .rts_n(rts_n),
      .sync_n_in(sync_pin), .sync_n_out(sync_n_out), .sync_n_oe(sync_n_oe),
      .tx_buffer_empty(tx_buffer_empty), .eom_status(eom_status),
      .cts_status(cts_status), .hunt_status(hunt_status),
      .ext_status_event(), .parity_error(parity_error),
      .special_rx_event(), .rx_fifo_data(rx_fifo_data),
      .rx_fifo_valid(rx_fifo_valid));
   sync_line_model #(.DIV(4)) line_u (.core_clk(core_clk), .reset_n(reset_n),
      .tx_data(tx_data), .tx_bit_en(tx_bit_en), .rx_bit_en(rx_bit_en),
      .rx_data(rx_data), .ext_sync_n(ext_sync_n));
   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (rx_fifo_valid) got.push_back(rx_fifo_data);
      if (cycles == 20000) begin
         n_errors++;
         complete_run();
      end
   end
   function automatic logic [7:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng[7:0];
   endfunction : rnd
   function automatic logic [15:0] crc_of(logic [7:0] d, logic c16, pre);
      logic [15:0] c;
      logic fb;
      c = {16{pre}};
      for (int i = 0; i < 8; i++) begin
         fb = d[i] ^ c[15];
         c = {c[14:0], 1'b0} ^ (fb ? (c16 ? 16'h8005 : 16'h1021) : 16'h0000);
      end
      return c;
   endfunction : crc_of
   // Data LSB first, then the CRC MSB first, anywhere in the capture
   function automatic logic found(logic [7:0] d, logic [15:0] c);
      logic ok;
      for (int k = 0; k + 24 <= line_u.tx_seen.size(); k++) begin
         ok = 1'b1;
         for (int j = 0; j < 24; j++)
            ok &= line_u.tx_seen[k + j] === (j < 8 ? d[j] : c[23 - j]);
         if (ok) return 1'b1;
      end
      return 1'b0;
   endfunction : found
   task automatic check(input logic [15:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check
   task automatic wreg(input int idx, input logic [7:0] d);
      @(posedge core_clk) #2;
      wr_data = d;
      wr[idx] = 1'b1;
      @(posedge core_clk) #2;
      wr = 10'h000;
   endtask : wreg
   task automatic complete_run();
      if (n_errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   initial begin
      logic [7:0] d;
      logic [7:0] e;
      logic [15:0] c;
      repeat (6) @(posedge core_clk);
      #2 reset_n = 1'b1;
      for (int i = 0; i < 6; i++) begin
         d = rnd();
         wreg(4, d & 8'hF7);
         cts_n = d[7];
         repeat (3) @(posedge core_clk);
         check(rts_n, !d[1]);
         check(cts_status, !d[7]);
      end
      wreg(5, 8'h16);
      wreg(6, 8'h16);
      wreg(3, 8'h03);
      wreg(1, 8'h04);
      wreg(2, 8'hD3);
      repeat (2) @(posedge core_clk);
      check(hunt_status, 1);
      // Set bit 7 so random data can never be stripped as sync
      d = rnd() | 8'h80;
      e = rnd() | 8'h80;
      line_u.send(16'h0016, 8, 0);
      line_u.send({^8'h16, 8'h16}, 9, 0);
      line_u.send({^d, d}, 9, 0);
      line_u.send({~^e, e}, 9, 0);
      // The idle line keeps forming characters, so stop at the second one
      for (int k = 0; k < 400 && got.size() < 2; k++) @(posedge core_clk);
      check(hunt_status, 0);
      check(got.size(), 2);
      check(got.pop_front(), d);
      check(got.pop_front(), e);
      check(parity_error, 1);
      wreg(2, 8'hC3);
      repeat (3) @(posedge core_clk);
      check(hunt_status, 0);
      check(parity_error, 1);
      // Hunt stops idle characters from setting the error again
      wreg(2, 8'hD3);
      repeat (3) @(posedge core_clk);
      check(hunt_status, 1);
      wreg(0, 8'h30);
      repeat (3) @(posedge core_clk);
      check(parity_error, 0);
      wreg(3, 8'h33);
      wreg(2, 8'hD3);
      line_u.send(16'h00A5, 8, 1);
      repeat (3) @(posedge core_clk);
      check(hunt_status, 1);
      for (int k = 0; k < 200 && sync_pin; k++) @(posedge core_clk);
      repeat (3) @(posedge core_clk);
      check(hunt_status, 0);
      wreg(3, 8'h00);
      for (int i = 0; i < 2; i++) begin
         wreg(8, i ? 8'h00 : 8'h80);
         wreg(7, i ? 8'h02 : 8'h00);
         wreg(4, i ? 8'h63 : 8'h67);
         wreg(4, i ? 8'h6B : 8'h6F);
         wreg(0, 8'h80);
         repeat (40) @(posedge core_clk);
         d = rnd();
         check(tx_buffer_empty, 1);
         line_u.tx_seen.delete();
         wreg(9, d);
         if (i == 0) wreg(0, 8'hC0);
         for (int k = 0; k < 60 && eom_status; k++) @(posedge core_clk);
         check(eom_status, 0);
         for (int k = 0; k < 800 && !eom_status; k++) @(posedge core_clk);
         repeat (12) @(posedge core_clk);
         c = crc_of(d, i == 0, i == 0);
         check(eom_status, 1);
         check(found(d, c), 1);
      end
      complete_run();
   end
endmodule : byte_sync_tx_rx_framing_tb_top
bind byte_sync_tx_rx_framing byte_sync_tx_rx_framing_monitor mon_u (
   .core_clk(core_clk), .reset_n(reset_n), .wr_data(wr_data),
   .command_reg_wr(command_reg_wr),
   .receive_control_reg_wr(receive_control_reg_wr),
   .channel_mode_reg_wr(channel_mode_reg_wr),
   .transmit_control_reg_wr(transmit_control_reg_wr),
   .cts_n(cts_n), .rts_n(rts_n), .sync_n_in(sync_n_in),
   .sync_n_out(sync_n_out), .sync_n_oe(sync_n_oe),
   .eom_status(eom_status), .cts_status(cts_status),
   .hunt_status(hunt_status), .ext_status_event(ext_status_event),
   .parity_error(parity_error), .special_rx_event(special_rx_event));
